// *** hdl/pfs_cycle_timer.sv ***
`timescale 1ns/10ps
module pfs_cycle_timer (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Phase
  output logic [1:0] o_phase,
  output logic o_cycle_end
);
  import pfs_pkg::*;
  // ------------------------------------------------------------
  // Fixed divide by four, nothing can reprogram it
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_phase <= 2'h0;
      o_cycle_end <= 1'b0;
    end else begin
      o_phase <= o_phase + 2'h1;
      o_cycle_end <= (o_phase == PHASE_LAST - 2'h1);
    end
  end
  cycle_len_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_cycle_end |=> !o_cycle_end [*3] ##1 o_cycle_end) else $error("cycle not 4 clocks");
endmodule : pfs_cycle_timer

// *** hdl/pfs_pkg.sv ***
package pfs_pkg;
  // ------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [4:0] OP_BLOCK_JUMP = 5'h01;
  localparam logic [4:0] OP_BLOCK_JUMP_MASK = 5'h1F;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_RETURN = 8'h22;
  localparam logic [7:0] OP_RETURN_INT = 8'h32;
  localparam logic [7:0] OP_BIT_JUMP = 8'h20;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_NOP = 8'h00;
  // ------------------------------------------------------------
  // Addresses and timing
  // ------------------------------------------------------------
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] BLOCK_MASK = 16'h07FF;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [15:0] IRQ_VECTOR = 16'h0003;
  localparam int CLKS_PER_CYCLE = 4;
  localparam int SLOW_CYCLES = 4;
  localparam int MID_CYCLES = 2;
  localparam logic [1:0] PHASE_LAST = 2'(CLKS_PER_CYCLE - 1);
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PFS_FETCH = 3'b000,
    PFS_OPND1 = 3'b001,
    PFS_OPND2 = 3'b010,
    PFS_EXEC = 3'b011,
    PFS_POPHI = 3'b100,
    PFS_POPLO = 3'b101
  } pfs_state_t;
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } pfs_code_req_t;
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pfs_stack_req_t;
endpackage : pfs_pkg

// *** hdl/pfs_sequencer.sv ***
`timescale 1ns/10ps
module pfs_sequencer (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Code memory
  output pfs_pkg::pfs_code_req_t o_code,
  input wire logic [7:0] i_code_data,
  // Stack RAM
  output pfs_pkg::pfs_stack_req_t o_stack,
  input wire logic [7:0] i_stack_data,
  // Control
  input wire logic i_irq,
  input wire logic i_bit_value,
  // Status
  output logic [15:0] o_pc,
  output logic o_in_handler,
  output logic o_instr_done
);
  import pfs_pkg::*;

  pfs_state_t state;
  logic [1:0] phase;
  logic cycle_end;
  logic [7:0] opcode;
  logic [7:0] opnd1;
  logic [7:0] opnd2;
  logic [15:0] fetch_pc;
  logic [7:0] sp;
  logic [2:0] cycles_left;
  logic [1:0] push_step;
  logic irq_meta;
  logic irq_sync;
  logic irq_pending;
  logic [15:0] next_pc;
  logic [15:0] seq_pc;
  logic push_req;
  logic [15:0] push_val;
  logic [2:0] need_cycles;

  pfs_cycle_timer u_timer (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .o_phase(phase),
    .o_cycle_end(cycle_end)
  );

  // ------------------------------------------------------------
  // Interrupt pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      irq_meta <= i_irq;
      irq_sync <= irq_meta;
    end
  end

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] instr_len(input logic [7:0] op);
    if (op == OP_LONG_JUMP || op == OP_LONG_CALL || op == OP_BIT_JUMP) begin
      instr_len = 2'd3;
    end else if (op == OP_SHORT_JUMP || (op[4:0] & OP_BLOCK_JUMP_MASK) == OP_BLOCK_JUMP) begin
      instr_len = 2'd2;
    end else begin
      instr_len = 2'd1;
    end
  endfunction : instr_len

  always_comb begin
    seq_pc = fetch_pc; // fetch_pc already points past the last byte fetched
    next_pc = seq_pc;
    need_cycles = 3'd1;
    push_req = 1'b0;
    push_val = seq_pc;
    if (opcode == OP_LONG_JUMP) begin
      next_pc = {opnd1, opnd2};
      need_cycles = 3'(MID_CYCLES);
    end else if (opcode == OP_LONG_CALL) begin
      next_pc = {opnd1, opnd2};
      push_req = 1'b1;
      need_cycles = 3'(MID_CYCLES);
    end else if (opcode == OP_SHORT_JUMP) begin
      next_pc = seq_pc + {{8{opnd1[7]}}, opnd1};
      need_cycles = 3'(MID_CYCLES);
    end else if (opcode[4:0] == OP_BLOCK_JUMP) begin
      next_pc = (seq_pc & ~BLOCK_MASK) | {5'h00, opcode[7:5], opnd1};
      need_cycles = 3'(MID_CYCLES);
    end else if (opcode == OP_BIT_JUMP) begin
      if (i_bit_value) begin
        next_pc = seq_pc + {{8{opnd2[7]}}, opnd2};
      end
      need_cycles = 3'(MID_CYCLES);
    end else if (opcode == OP_MUL || opcode == OP_DIV) begin
      need_cycles = 3'(SLOW_CYCLES);
    end else if (opcode == OP_RETURN || opcode == OP_RETURN_INT) begin
      need_cycles = 3'(MID_CYCLES);
    end
  end

  // ------------------------------------------------------------
  // Sequencer, one step per instruction cycle
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= PFS_FETCH;
      o_pc <= PC_RESET;
      fetch_pc <= PC_RESET;
      opcode <= OP_NOP;
      opnd1 <= 8'h00;
      opnd2 <= 8'h00;
      sp <= SP_RESET;
      cycles_left <= 3'd0;
      push_step <= 2'd0;
      irq_pending <= 1'b0;
      o_in_handler <= 1'b0;
      o_instr_done <= 1'b0;
      o_code <= '0;
      o_stack <= '0;
    end else begin
      o_instr_done <= 1'b0;
      o_stack.we <= 1'b0;
      o_stack.re <= 1'b0;
      o_code.rd <= 1'b0;
      if (irq_sync && !o_in_handler) begin
        irq_pending <= 1'b1;
      end
      // Stack writes use otherwise idle phases of the execute cycle
      if (push_step != 2'd0) begin
        o_stack.we <= 1'b1;
        o_stack.addr <= sp + 8'h01;
        o_stack.wdata <= (push_step == 2'd2) ? push_val[7:0] : push_val[15:8];
        sp <= sp + 8'h01;
        push_step <= push_step - 2'd1;
      end
      if (cycle_end) begin
        case (state)
          PFS_FETCH: begin
            if (irq_pending) begin
              // Take the interrupt between instructions so no state is half done
              opcode <= OP_LONG_CALL;
              {opnd1, opnd2} <= IRQ_VECTOR;
              irq_pending <= 1'b0;
              o_in_handler <= 1'b1;
              // Start at one so the entry pushes its return address like a real call
              cycles_left <= 3'd1;
              state <= PFS_EXEC;
            end else begin
              opcode <= i_code_data;
              fetch_pc <= fetch_pc + 16'h0001;
              state <= (instr_len(i_code_data) > 2'd1) ? PFS_OPND1 : PFS_EXEC;
              cycles_left <= 3'd1;
              o_code.addr <= fetch_pc + 16'h0001;
              o_code.rd <= 1'b1;
            end
          end
          PFS_OPND1: begin
            opnd1 <= i_code_data;
            fetch_pc <= fetch_pc + 16'h0001;
            state <= (instr_len(opcode) == 2'd3) ? PFS_OPND2 : PFS_EXEC;
            o_code.addr <= fetch_pc + 16'h0001;
            o_code.rd <= (instr_len(opcode) == 2'd3);
          end
          PFS_OPND2: begin
            opnd2 <= i_code_data;
            fetch_pc <= fetch_pc + 16'h0001;
            state <= PFS_EXEC;
          end
          PFS_EXEC: begin
            if (cycles_left < need_cycles) begin
              cycles_left <= cycles_left + 3'd1;
              if (push_req && cycles_left == 3'd1) begin
                push_step <= 2'd2;
              end
            end else if (opcode == OP_RETURN || opcode == OP_RETURN_INT) begin
              o_stack.re <= 1'b1;
              o_stack.addr <= sp;
              sp <= sp - 8'h01;
              state <= PFS_POPHI;
            end else begin
              o_pc <= next_pc;
              fetch_pc <= next_pc;
              o_code.addr <= next_pc;
              o_code.rd <= 1'b1;
              o_instr_done <= 1'b1;
              state <= PFS_FETCH;
            end
          end
          PFS_POPHI: begin
            fetch_pc[15:8] <= i_stack_data;
            o_stack.re <= 1'b1;
            o_stack.addr <= sp;
            sp <= sp - 8'h01;
            state <= PFS_POPLO;
          end
          PFS_POPLO: begin
            o_pc <= {fetch_pc[15:8], i_stack_data};
            fetch_pc <= {fetch_pc[15:8], i_stack_data};
            o_code.addr <= {fetch_pc[15:8], i_stack_data};
            o_code.rd <= 1'b1;
            if (opcode == OP_RETURN_INT) begin
              o_in_handler <= 1'b0;
            end
            o_instr_done <= 1'b1;
            state <= PFS_FETCH;
          end
          default: begin
            state <= PFS_FETCH;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  reset_pc_a: assert property (@(posedge i_core_clk) $rose(i_reset_n) |-> o_pc == PC_RESET)
    else $error("pc not zero after reset");
  cycle_phase_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    cycle_end |-> phase == PHASE_LAST) else $error("cycle end off phase");
  long_jump_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cycle_end && state == PFS_EXEC && opcode == OP_LONG_JUMP && cycles_left >= need_cycles)
    |=> o_pc == $past({opnd1, opnd2})) else $error("long jump target wrong");
  short_jump_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cycle_end && state == PFS_EXEC && opcode == OP_SHORT_JUMP && cycles_left >= need_cycles)
    |=> o_pc == $past(fetch_pc + {{8{opnd1[7]}}, opnd1})) else $error("short jump target wrong");
  block_jump_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cycle_end && state == PFS_EXEC && opcode[4:0] == OP_BLOCK_JUMP && cycles_left >= need_cycles)
    |=> o_pc[15:11] == $past(fetch_pc[15:11])) else $error("block jump left block");
  bit_fall_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cycle_end && state == PFS_EXEC && opcode == OP_BIT_JUMP && !i_bit_value && cycles_left >= need_cycles)
    |=> o_pc == $past(fetch_pc)) else $error("bit jump taken while clear");
  call_push_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(push_step == 2'd2) |=> o_stack.we ##1 o_stack.we && o_stack.addr == $past(o_stack.addr) + 8'h01)
    else $error("call push not two bytes");
  two_byte_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cycle_end && state == PFS_FETCH && !irq_pending && i_code_data == OP_SHORT_JUMP)
    |=> state == PFS_OPND1) else $error("short jump not two bytes");
  slow_op_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cycle_end && state == PFS_FETCH && !irq_pending && i_code_data == OP_MUL)
    |-> ##17 o_instr_done) else $error("slow op not 16 clocks");
endmodule : pfs_sequencer

// *** testbench/pfs_mem_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Code memory and stack RAM
// ------------------------------------------------------------
module pfs_mem_model
  import pfs_pkg::*;
(
  // Clock
  input wire logic i_core_clk,
  // Requests
  input wire pfs_pkg::pfs_code_req_t i_code,
  input wire pfs_pkg::pfs_stack_req_t i_stack,
  // Answers
  output logic [7:0] o_code_data,
  output logic [7:0] o_stack_data
);
  logic [7:0] code [0:1023];
  logic [7:0] stk [0:255];
  // Address is held by the sequencer, so a plain lookup is ready at the sampling edge
  assign o_code_data = code[i_code.addr[9:0]];
  always @(posedge i_core_clk) begin
    if (i_stack.we) begin
      stk[i_stack.addr] <= i_stack.wdata;
    end
    if (i_stack.re) begin
      o_stack_data <= stk[i_stack.addr];
    end
  end
endmodule : pfs_mem_model

// *** testbench/tb_program_flow_sequencer.sv ***
`timescale 1ns/10ps
module tb_program_flow_sequencer;
  import pfs_pkg::*;
  logic i_core_clk, i_reset_n, i_irq, i_bit_value, in_handler, instr_done, b;
  pfs_code_req_t code_req;
  pfs_stack_req_t stack_req;
  logic [7:0] code_data, stack_data;
  logic [15:0] pc;
  logic [7:0] img [0:1023];
  logic [15:0] stack_q[$];
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  int n, i;

  pfs_sequencer pfs_sequencer_i (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .o_code(code_req),
    .i_code_data(code_data), .o_stack(stack_req), .i_stack_data(stack_data), .i_irq(i_irq),
    .i_bit_value(i_bit_value), .o_pc(pc), .o_in_handler(in_handler), .o_instr_done(instr_done));
  pfs_mem_model pfs_mem_model_i (.i_core_clk(i_core_clk), .i_code(code_req), .i_stack(stack_req),
    .o_code_data(code_data), .o_stack_data(stack_data));

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  // Generous ceiling: two runs of the short program plus one interrupt need well under 2000 clocks
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task put(input logic [15:0] a, input logic [23:0] v, input int cnt);
    for (int k = 0; k < cnt; k++) img[a[9:0] + 10'(k)] = v[8 * (cnt - 1 - k) +: 8];
  endtask : put
  task wait_done(output int c);
    c = 0;
    do begin
      @(posedge i_core_clk);
      #1;
      c++;
    end while (instr_done !== 1'b1 && c < 200);
    // A missing completion counts as a failure even if the counter happens to match
    if (instr_done !== 1'b1) error_cnt++;
  endtask : wait_done
  // Reference model of one instruction: next counter and clock count
  task model(inout logic [15:0] mpc, output int clk);
    logic [7:0] op, b1, b2;
    logic [15:0] nx;
    op = img[mpc[9:0]];
    b1 = img[mpc[9:0] + 10'h001];
    b2 = img[mpc[9:0] + 10'h002];
    nx = mpc + 16'h0002;
    clk = 16;
    if (op == OP_LONG_JUMP) begin mpc = {b1, b2}; clk = 20; end
    else if (op == OP_SHORT_JUMP) mpc = nx + {{8{b1[7]}}, b1};
    else if (op[4:0] == OP_BLOCK_JUMP) mpc = {nx[15:11], op[7:5], b1};
    else if (op == OP_LONG_CALL) begin stack_q.push_back(mpc + 16'h0003); mpc = {b1, b2}; clk = 20; end
    else if (op == OP_RETURN) begin mpc = stack_q.pop_back(); clk = 20; end
    else if (op == OP_BIT_JUMP) begin mpc = mpc + 16'h0003 + (b ? {{8{b2[7]}}, b2} : 16'h0000); clk = 20; end
    else if (op == OP_MUL || op == OP_DIV) begin mpc = mpc + 16'h0001; clk = 20; end
    else begin mpc = mpc + 16'h0001; clk = 8; end
  endtask : model
  task run;
    logic [15:0] mpc;
    int c, e;
    @(posedge i_core_clk);
    i_reset_n <= 1'b0;
    i_bit_value <= b;
    repeat (16) @(posedge i_core_clk);
    #1;
    chk(pc, PC_RESET);
    @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    mpc = PC_RESET;
    stack_q.delete();
    for (int k = 0; k < 12; k++) begin
      wait_done(c);
      model(mpc, e);
      chk(pc, mpc);
      if (k > 0) chk(16'(c), 16'(e));
      if (k == 3) chk({pfs_mem_model_i.stk[SP_RESET + 8'h02], pfs_mem_model_i.stk[SP_RESET + 8'h01]}, 16'h0113);
    end
  endtask : run
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    i_reset_n = 1'b0;
    i_irq = 1'b0;
    i_bit_value = 1'b0;
    for (i = 0; i < 1024; i++) img[i] = 8'h00;
    put(16'h0000, 24'h020100, 3);
    put(16'h0100, 24'h00807F, 2);
    put(16'h0181, 24'h002110, 2);
    put(16'h0110, 24'h120200, 3);
    put(16'h0200, 24'h000022, 2);
    put(16'h0113, 24'h200003, 3);
    put(16'h0116, 24'h008001, 2);
    put(16'h0119, 24'hA48480, 3);
    put(16'h011C, 24'h000080, 1);
    put(16'h009D, 24'h0080FE, 2);
    put(16'h0003, 24'h000032, 1);
    for (i = 0; i < 1024; i++) pfs_mem_model_i.code[i] = img[i];
    void'($urandom(53));
    b = 1'($urandom());
    run();
    b = ~b;
    run();
    // Interrupt while looping at 009D: handler returns at once
    @(posedge i_core_clk);
    i_irq <= 1'b1;
    n = 0;
    while (in_handler !== 1'b1 && n < 200) begin @(posedge i_core_clk); #1; n++; end
    chk(16'(in_handler), 16'h0001);
    @(posedge i_core_clk);
    i_irq <= 1'b0;
    n = 0;
    while (in_handler !== 1'b0 && n < 200) begin @(posedge i_core_clk); #1; n++; end
    chk(16'(in_handler), 16'h0000);
    chk({pfs_mem_model_i.stk[SP_RESET + 8'h02], pfs_mem_model_i.stk[SP_RESET + 8'h01]}, 16'h009D);
    wait_done(n);
    chk(pc, 16'h009D);
    end_sim();
  end
endmodule : tb_program_flow_sequencer
